// ### logic/bcrc_engine.sv
// bcrc_engine: byte crc engine with automatic flash sector mode.
// assumes a processor on an sfr bus with one-cycle read/write strobes and
// a flash read port that answers each request with one valid pulse later.
// Notes on behaviour
// RQ1 - select bit 0 gives 32-bit crc 0x04C11DB7, 1 gives 16-bit 0x1021
// RQ2 - writing 1 to result-init loads the whole result with the preset
// RQ3 - preset is all zeros when init-value select is 0, all ones when 1
// RQ4 - 32-bit mode: pointer 00..11 picks result bytes 7..0 up to 31..24
// RQ5 - 16-bit mode: pointer 00 and 10 pick bits 7..0, 01 and 11 bits 15..8
// RQ6 - pointer increments after each read or write of the data port, wrapping
// RQ7 - control bits 7 to 5 read zero, writes to them are ignored
// RQ8 - each byte input write is folded into the result by the chosen width
// RQ9 - data port read returns the pointed byte, write replaces that byte
// RQ10 - control write with auto enable starts flash crc from start sector
// RQ11 - done flag is 0 during automatic calculation, 1 otherwise
// RQ12 - processor is stalled for the whole automatic calculation
// RQ13 - five-bit start sector gives first sector, byte address times 512
// RQ14 - 16-bit mode: xor byte into upper byte, shift left eight, poly 0x1021
// RQ15 - 32-bit mode reflected: xor low byte, shift right eight, 0xEDB88320
// RQ16 - six-bit sector count gives number of 512-byte sectors covered
// RQ17 - result holds until initialised, overwritten or updated by a byte
// RQ18 - automatic mode fetches ascending addresses through the same update
// RQ19 - 16-bit mode uses only the low sixteen result bits
module bcrc_engine (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic cpu_stall,
  output logic flash_rd_en,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rdata_valid
);
  import bcrc_pkg::*;

  // RQ14 RQ15 RQ19 byte step
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b,
                                           input logic sel16);
    logic [31:0] r32;
    logic [15:0] r16;
    r32 = c ^ {24'h000000, b};
    r16 = c[15:0] ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r32 = r32[0] ? ((r32 >> 1) ^ BCRC_POLY32_REFL) : (r32 >> 1);
      r16 = r16[15] ? ({r16[14:0], 1'b0} ^ BCRC_POLY16) : {r16[14:0], 1'b0};
    end
    // upper half left untouched in 16-bit mode
    return sel16 ? {c[31:16], r16} : r32;
  endfunction : crc_step

  logic [31:0] crc_q, crc_d, crc_upd;
  logic sel_q, val_q, auto_en_q, pend_q, stall_q, rd_en_q;
  logic [1:0] ptr_q, ptr_d;
  logic [4:0] start_q;
  logic [5:0] cnt_q;
  logic [7:0] in_q, rdata_q;
  logic [15:0] fetch_addr_q, flash_addr_q;
  logic [14:0] rem_q;
  bcrc_state_t st_q, st_d;
  logic [7:0] fifo_q [2];
  logic fifo_wp_q, fifo_rp_q;
  logic [1:0] fifo_cnt_q;

  // bus decode; writes are ignored while the engine owns the result
  wire busy = (st_q != BCRC_IDLE);
  wire wr_ok = sfr_wr && !busy;
  wire ctrl_wr = wr_ok && (sfr_addr == BCRC_CTRL_ADDR);
  wire auto_wr = wr_ok && (sfr_addr == BCRC_AUTO_ADDR);
  wire cnt_wr = wr_ok && (sfr_addr == BCRC_CNT_ADDR);
  wire in_wr = wr_ok && (sfr_addr == BCRC_IN_ADDR);
  wire dat_wr = wr_ok && (sfr_addr == BCRC_DAT_ADDR);
  wire dat_rd = sfr_rd && (sfr_addr == BCRC_DAT_ADDR);
  wire init_wr = ctrl_wr && sfr_wdata[BCRC_INIT_BIT];
  // RQ10 start on control write
  wire start = ctrl_wr && auto_en_q;

  // width follows the written select when the same write also initialises
  wire sel_now = ctrl_wr ? sfr_wdata[BCRC_SEL_BIT] : sel_q;

  // RQ4 RQ5 pointer to byte lane
  wire [1:0] lane = sel_q ? {1'b0, ptr_q[0]} : ptr_q;
  wire [7:0] dat_byte = crc_q[{lane, 3'b000} +: 8];

  // two-entry buffer between flash and the crc update
  wire fifo_fill_rdy = (fifo_cnt_q != 2'd2);
  wire push = flash_rdata_valid && pend_q && fifo_fill_rdy;
  wire drain_rdy = busy;
  wire fifo_valid = (fifo_cnt_q != 2'd0);
  wire pop = fifo_valid && drain_rdy;
  wire [7:0] fifo_out = fifo_q[fifo_rp_q];

  // issue a flash read only when the answer has a slot waiting
  wire issue = (st_q == BCRC_FETCH) && !pend_q && !rd_en_q && (fifo_cnt_q == 2'd0) &&
               (rem_q != 15'd0);

  // RQ2 RQ3 preset selection
  wire [31:0] preset = sfr_wdata[BCRC_VAL_BIT] ? BCRC_PRESET_ONES : BCRC_PRESET_ZERO;

  // RQ8 RQ17 RQ18 update source; one source per cycle at most
  assign crc_upd = init_wr ? preset :
                   in_wr ? crc_step(crc_q, sfr_wdata, sel_q) :
                   pop ? crc_step(crc_q, fifo_out, sel_q) : crc_q;

  // RQ9 data port write replaces the pointed lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign crc_d[8*g +: 8] = (dat_wr && lane == 2'(g)) ? sfr_wdata : crc_upd[8*g +: 8];
  end

  // RQ6 pointer auto increment; control write reloads it
  assign ptr_d = ctrl_wr ? sfr_wdata[BCRC_PTR_LSB +: 2] :
                 (dat_wr || dat_rd) ? ptr_q + 2'd1 : ptr_q;

  // RQ7 RQ11 read mux; done reads 1 since the cpu is stalled while busy
  wire [7:0] rd_mux =
    (sfr_addr == BCRC_CTRL_ADDR) ? {3'b000, sel_q, 1'b0, val_q, ptr_q} :
    (sfr_addr == BCRC_AUTO_ADDR) ? {auto_en_q, !busy, 1'b0, start_q} :
    (sfr_addr == BCRC_CNT_ADDR) ? {2'b00, cnt_q} :
    (sfr_addr == BCRC_IN_ADDR) ? in_q :
    (sfr_addr == BCRC_DAT_ADDR) ? dat_byte : 8'h00;

  // automatic sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      BCRC_IDLE: begin
        if (start) begin
          st_d = (cnt_q == 6'd0) ? BCRC_DRAIN : BCRC_FETCH;
        end
      end
      BCRC_FETCH: begin
        if (issue && rem_q == 15'd1) begin
          st_d = BCRC_DRAIN;
        end
      end
      BCRC_DRAIN: begin
        if (!pend_q && !rd_en_q && !fifo_valid) begin
          st_d = BCRC_IDLE;
        end
      end
      default: st_d = BCRC_IDLE;
    endcase
  end

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q <= BCRC_CTRL_RST[BCRC_SEL_BIT];
      val_q <= BCRC_CTRL_RST[BCRC_VAL_BIT];
      auto_en_q <= BCRC_AUTO_RST[BCRC_AUTO_CALC_ENABLE_BIT];
      start_q <= BCRC_AUTO_RST[BCRC_START_LSB +: 5];
      cnt_q <= BCRC_CNT_RST;
      in_q <= BCRC_IN_RST;
    end else begin
      // RQ1 width select
      if (ctrl_wr) begin
        sel_q <= sel_now;
        val_q <= sfr_wdata[BCRC_VAL_BIT];
      end
      if (auto_wr) begin
        auto_en_q <= sfr_wdata[BCRC_AUTO_CALC_ENABLE_BIT];
        start_q <= sfr_wdata[BCRC_START_LSB +: 5];
      end
      // RQ16 sector count
      if (cnt_wr) begin
        cnt_q <= sfr_wdata[5:0];
      end
      if (in_wr) begin
        in_q <= sfr_wdata;
      end
    end
  end

  // result, pointer and read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_q <= BCRC_RESULT_RST;
      ptr_q <= BCRC_CTRL_RST[BCRC_PTR_LSB +: 2];
      rdata_q <= 8'h00;
    end else begin
      crc_q <= crc_d;
      ptr_q <= ptr_d;
      if (sfr_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // RQ12 RQ13 RQ18 sequencer, fetch address and stall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= BCRC_IDLE;
      fetch_addr_q <= 16'h0000;
      flash_addr_q <= 16'h0000;
      rem_q <= 15'd0;
      pend_q <= 1'b0;
      rd_en_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      st_q <= st_d;
      stall_q <= (st_d != BCRC_IDLE);
      rd_en_q <= issue;
      pend_q <= issue || (pend_q && !flash_rdata_valid);
      if (start) begin
        fetch_addr_q <= {2'b00, start_q, 9'h000};
        rem_q <= {cnt_q, 9'h000};
      end else if (issue) begin
        fetch_addr_q <= fetch_addr_q + 16'd1;
        rem_q <= rem_q - 15'd1;
        flash_addr_q <= fetch_addr_q;
      end
    end
  end

  // buffer storage, one flip-flop byte per entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fifo_q[0] <= 8'h00;
      fifo_q[1] <= 8'h00;
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'd0;
    end else begin
      if (push) begin
        fifo_q[fifo_wp_q] <= flash_rdata;
        fifo_wp_q <= !fifo_wp_q;
      end
      if (pop) begin
        fifo_rp_q <= !fifo_rp_q;
      end
      fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  assign sfr_rdata = rdata_q;
  assign cpu_stall = stall_q;
  assign flash_rd_en = rd_en_q;
  assign flash_addr = flash_addr_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // RQ2 RQ3 preset load
  property p_init_preset;
    init_wr |=> crc_q == ($past(sfr_wdata[BCRC_VAL_BIT]) ? 32'hFFFFFFFF : 32'h00000000);
  endproperty
  a_init_preset: assert property (p_init_preset) else $error("init preset wrong"); // RQ2

  // RQ4 top lane read in 32-bit mode
  property p_lane32;
    dat_rd && !sel_q && ptr_q == 2'd3 |=> sfr_rdata == $past(crc_q[31:24]);
  endproperty
  a_lane32: assert property (p_lane32) else $error("32-bit lane wrong"); // RQ4

  // RQ5 pointer 10 aliases low byte in 16-bit mode
  property p_lane16;
    dat_rd && sel_q && ptr_q == 2'd2 |=> sfr_rdata == $past(crc_q[7:0]);
  endproperty
  a_lane16: assert property (p_lane16) else $error("16-bit lane wrong"); // RQ5

  // RQ6 pointer advance
  property p_ptr_inc;
    (dat_rd || dat_wr) && !ctrl_wr |=> ptr_q == $past(ptr_q) + 2'd1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced"); // RQ6

  // RQ7 unused control bits
  property p_ctrl_zero;
    sfr_rd && sfr_addr == BCRC_CTRL_ADDR |=> sfr_rdata[7:5] == 3'b000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control high bits set"); // RQ7

  // RQ10 RQ12 start stalls the cpu next cycle
  property p_start_stall;
    start |=> cpu_stall && busy;
  endproperty
  a_start_stall: assert property (p_start_stall) else $error("no stall on start"); // RQ12

  // RQ13 first fetch address
  property p_first_addr;
    start && cnt_q != 6'd0 |=> ##[1:3] flash_rd_en &&
      flash_addr == {2'b00, $past(start_q, 2), 9'h000};
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first sector address"); // RQ13

  // RQ12 stall covers exactly the busy span
  property p_busy_stall;
    cpu_stall == busy;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("stall mismatch"); // RQ12

  // RQ19 upper half untouched in 16-bit mode
  property p_upper16;
    in_wr && sel_q |=> crc_q[31:16] == $past(crc_q[31:16]);
  endproperty
  a_upper16: assert property (p_upper16) else $error("upper half changed"); // RQ19

  // RQ17 result holds without a source
  property p_hold;
    !init_wr && !in_wr && !dat_wr && !pop |=> $stable(crc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed"); // RQ17

  // RQ11 done reads one when the cpu can see it
  property p_done_read;
    sfr_rd && sfr_addr == BCRC_AUTO_ADDR && !busy |=> sfr_rdata[BCRC_DONE_BIT];
  endproperty
  a_done_read: assert property (p_done_read) else $error("done flag low"); // RQ11

  // RQ14 known 16-bit vector from all-ones preset
  property p_vec16;
    in_wr && sel_q && crc_q[15:0] == 16'hFFFF && sfr_wdata == 8'h63 |=>
      crc_q[15:0] == 16'hBD35;
  endproperty
  a_vec16: assert property (p_vec16) else $error("16-bit vector wrong"); // RQ14

  // RQ15 known 32-bit vector from all-ones preset
  property p_vec32;
    in_wr && !sel_q && crc_q == 32'hFFFFFFFF && sfr_wdata == 8'h63 |=>
      crc_q == 32'hF9462090;
  endproperty
  a_vec32: assert property (p_vec32) else $error("32-bit vector wrong"); // RQ15

  // RQ16 zero sectors releases the cpu after one stalled cycle, no fetch
  property p_count_zero;
    start && cnt_q == 6'd0 |=> ##1 !cpu_stall && !flash_rd_en;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("empty run stalled"); // RQ16

  // RQ18 each request is a single pulse
  property p_rd_pulse;
    flash_rd_en |=> !flash_rd_en;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request held"); // RQ18

  // RQ18 next fetch is one byte above the issued one
  property p_addr_step;
    flash_rd_en |-> fetch_addr_q == flash_addr + 16'd1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("fetch not ascending"); // RQ18

  // RQ9 data port write lands in the low lane
  property p_dat_write;
    dat_wr && ptr_q == 2'd0 |=> crc_q[7:0] == $past(sfr_wdata);
  endproperty
  a_dat_write: assert property (p_dat_write) else $error("result byte not written"); // RQ9
endmodule : bcrc_engine

// ### include/bcrc_pkg.sv
// bcrc_pkg: register map, field positions, reset values and state codes
// for the byte crc engine; assumes an 8-bit special function register bus.
package bcrc_pkg;
  // register addresses on the sfr bus
  localparam logic [7:0] BCRC_CTRL_ADDR = 8'hCE;
  localparam logic [7:0] BCRC_AUTO_ADDR = 8'hD2;
  localparam logic [7:0] BCRC_CNT_ADDR = 8'hD3;
  localparam logic [7:0] BCRC_IN_ADDR = 8'hDD;
  localparam logic [7:0] BCRC_DAT_ADDR = 8'hDE;
  // control register fields
  localparam int BCRC_SEL_BIT = 4;
  localparam int BCRC_INIT_BIT = 3;
  localparam int BCRC_VAL_BIT = 2;
  localparam int BCRC_PTR_LSB = 0;
  // automatic control register fields
  localparam int BCRC_AUTO_CALC_ENABLE_BIT = 7;
  localparam int BCRC_DONE_BIT = 6;
  localparam int BCRC_START_LSB = 0;
  // reset values
  localparam logic [7:0] BCRC_CTRL_RST = 8'h00;
  localparam logic [7:0] BCRC_AUTO_RST = 8'h40;
  localparam logic [7:0] BCRC_IN_RST = 8'h00;
  localparam logic [5:0] BCRC_CNT_RST = 6'h00;
  localparam logic [31:0] BCRC_RESULT_RST = 32'h00000000;
  // presets and polynomials
  localparam logic [31:0] BCRC_PRESET_ZERO = 32'h00000000;
  localparam logic [31:0] BCRC_PRESET_ONES = 32'hFFFFFFFF;
  localparam logic [15:0] BCRC_POLY16 = 16'h1021;
  localparam logic [31:0] BCRC_POLY32_REFL = 32'hEDB88320;
  // one flash sector is 512 bytes
  localparam int BCRC_SECTOR_SHIFT = 9;
  // automatic engine states, gray along idle, fetch, drain
  typedef enum logic [1:0] {
    BCRC_IDLE = 2'b00,
    BCRC_FETCH = 2'b01,
    BCRC_DRAIN = 2'b11
  } bcrc_state_t;
endpackage : bcrc_pkg

// ### test/bcrc_flash_model.sv
// bcrc_flash_model: flash read port answering one request at a time.
// assumes requests are one-cycle pulses with a held byte address.
module bcrc_flash_model (
  input wire logic core_clk,
  input wire logic flash_rd_en,
  input wire logic [15:0] flash_addr,
  input wire logic [3:0] lat,
  output logic [7:0] flash_rdata,
  output logic flash_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr_q = 16'h0000;
  logic [3:0] wait_q = 4'h0;
  logic busy_q = 1'b0;
  initial flash_rdata = 8'h00;
  initial flash_rdata_valid = 1'b0;
  // released data line toggles so a stale byte is never mistaken for fresh
  always @(posedge core_clk) begin
    flash_rdata_valid <= 1'b0;
    flash_rdata <= ~flash_rdata;
    if (flash_rd_en) begin
      busy_q <= 1'b1;
      addr_q <= flash_addr;
      wait_q <= lat;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      flash_rdata_valid <= 1'b1;
      flash_rdata <= addr_q[7:0] ^ addr_q[15:8] ^ 8'hA5;
    end
  end
endmodule : bcrc_flash_model

// ### test/byte_crc_engine_with_flash_auto_test.sv
// byte_crc_engine_with_flash_auto_test: bench with a behavioural crc model.
// assumes bcrc_pkg and the engine compiled before, flash model alongside.
module byte_crc_engine_with_flash_auto_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bcrc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, flash_rdata;
  logic cpu_stall, flash_rd_en, flash_rdata_valid;
  logic [15:0] flash_addr;
  logic [3:0] lat = 4'h0;
  int err_total = 0;
  int n_tests = 0;
  int n_fetch = 0;
  // bench model state
  logic [31:0] res = 32'h00000000, lfsr = 32'hf97b;
  logic [1:0] ptr = 2'b00;
  logic sel = 1'b0, val = 1'b0, aen = 1'b0;
  logic [4:0] st = 5'h00;
  logic [5:0] cnt = 6'h00;
  logic [7:0] inb = 8'h00;
  logic [15:0] exp_fa = 16'h0000;
  logic [7:0] regs [6] = '{8'hCE, 8'hD2, 8'hD3, 8'hDD, 8'hDE, 8'hCF};

  always #4 core_clk = ~core_clk;

  bcrc_engine uut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
    .flash_rd_en(flash_rd_en), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .flash_rdata_valid(flash_rdata_valid));
  bcrc_flash_model flash (.core_clk(core_clk), .flash_rd_en(flash_rd_en),
    .flash_addr(flash_addr), .lat(lat), .flash_rdata(flash_rdata),
    .flash_rdata_valid(flash_rdata_valid));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] upd(logic [31:0] r, logic [7:0] b, logic s);
    logic [31:0] a;
    a = r;
    if (s) begin
      a[15:8] = a[15:8] ^ b;
      for (int i = 0; i < 8; i++) a[15:0] = {a[14:0], 1'b0} ^ (a[15] ? BCRC_POLY16 : 16'h0000);
    end else begin
      a[7:0] = a[7:0] ^ b;
      for (int i = 0; i < 8; i++) a = (a >> 1) ^ (a[0] ? BCRC_POLY32_REFL : 32'h00000000);
    end
    return a;
  endfunction : upd

  // stimulus source; taps give a long sequence from the seed
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic int lane();
    return sel ? int'(ptr[0]) : int'(ptr);
  endfunction : lane

  // model of one accepted register write
  task automatic model(logic [7:0] a, logic [7:0] d);
    case (a)
      BCRC_CTRL_ADDR: begin
        sel = d[4];
        val = d[2];
        ptr = d[1:0];
        if (d[3]) res = val ? BCRC_PRESET_ONES : BCRC_PRESET_ZERO;
        if (aen) for (int k = 0; k < cnt * 512; k++) begin
          exp_fa = 16'(st * 512 + k);
          res = upd(res, exp_fa[7:0] ^ exp_fa[15:8] ^ 8'hA5, sel);
        end
        exp_fa = 16'(st * 512);
      end
      BCRC_AUTO_ADDR: {aen, st} = {d[7], d[4:0]};
      BCRC_CNT_ADDR: cnt = d[5:0];
      BCRC_IN_ADDR: {inb, res} = {d, upd(res, d, sel)};
      BCRC_DAT_ADDR: begin
        res[8 * lane() +: 8] = d;
        ptr = ptr + 2'b01;
      end
      default: ;
    endcase
  endtask : model

  // writes seen while stalled are refused, so the model skips them
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic busy;
    @(posedge core_clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    busy = cpu_stall;
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
    if (busy !== 1'b1) model(a, d);
  endtask : wr

  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    case (a)
      BCRC_CTRL_ADDR: e = {3'b000, sel, 1'b0, val, ptr};
      BCRC_AUTO_ADDR: e = {aen, 2'b10, st};
      BCRC_CNT_ADDR: e = {2'b00, cnt};
      BCRC_IN_ADDR: e = inb;
      BCRC_DAT_ADDR: e = res[8 * lane() +: 8];
      default: e = 8'h00;
    endcase
    @(posedge core_clk);
    #1 {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge core_clk);
    #1 sfr_rd = 1'b0;
    if (a == BCRC_DAT_ADDR) ptr = ptr + 2'b01;
    check($sformatf("reg_%h", a), sfr_rdata, e);
  endtask : rd

  task automatic auto_run(logic [4:0] s, logic [5:0] c, logic [3:0] l, logic [7:0] ctl);
    lat = l;
    wr(BCRC_AUTO_ADDR, {3'b100, s});
    wr(BCRC_CNT_ADDR, {2'b00, c});
    n_fetch = 0;
    wr(BCRC_CTRL_ADDR, ctl);
    if (c != 6'h00) check("stall", cpu_stall, 1'b1);
    wr(BCRC_IN_ADDR, 8'h77);
    for (int t = 0; t < 20000 && cpu_stall !== 1'b0; t++) @(posedge core_clk);
    #1 check("fetches", n_fetch, c * 512);
    check("stall_end", cpu_stall, 1'b0);
    wr(BCRC_AUTO_ADDR, 8'h00);
    rd(BCRC_AUTO_ADDR);
    rd(BCRC_IN_ADDR);
    repeat (4) rd(BCRC_DAT_ADDR);
  endtask : auto_run

  // every flash request must follow the ascending address walk
  always @(posedge core_clk) begin
    if (rst === 1'b0 && flash_rd_en === 1'b1) begin
      check("flash_addr", flash_addr, exp_fa);
      exp_fa++;
      n_fetch++;
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (regs[i]) rd(regs[i]);
    wr(BCRC_CTRL_ADDR, 8'hE0);
    rd(BCRC_CTRL_ADDR);
    for (int m = 0; m < 4; m++) begin
      wr(BCRC_CTRL_ADDR, {3'b000, m[1], 1'b1, m[0], 2'b11});
      repeat (4) rd(BCRC_DAT_ADDR);
      repeat (5) begin
        lfsr = lfsr_next(lfsr);
        wr(BCRC_IN_ADDR, lfsr[7:0]);
      end
      rd(BCRC_IN_ADDR);
      rd(BCRC_CTRL_ADDR);
      repeat (5) rd(BCRC_DAT_ADDR);
      wr(BCRC_DAT_ADDR, lfsr[15:8]);
      repeat (4) rd(BCRC_DAT_ADDR);
    end
    wr(BCRC_CTRL_ADDR, 8'h1C);
    wr(BCRC_IN_ADDR, 8'h63);
    check("vec16", res[15:0], 16'hBD35);
    repeat (2) rd(BCRC_DAT_ADDR);
    wr(BCRC_CTRL_ADDR, 8'h0C);
    wr(BCRC_IN_ADDR, 8'h63);
    check("vec32", res, 32'hF9462090);
    repeat (4) rd(BCRC_DAT_ADDR);
    auto_run(5'd3, 6'd1, 4'd0, 8'h0C);
    auto_run(5'd31, 6'd1, 4'd3, 8'h1C);
    auto_run(5'd5, 6'd0, 4'd0, 8'h08);
    conclude();
  end

  // watchdog sized well above the two sector runs
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    conclude();
  end
endmodule : byte_crc_engine_with_flash_auto_test
